/* File: design/input_latch_debounce_pkg.sv */
// shared constants for the debounced input latch block
`default_nettype none
package input_latch_debounce_pkg;

  // ----------------------------------------------------------------
  // clock
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;

  // ----------------------------------------------------------------
  // debounce times, in ns, and their cycle counts
  // ----------------------------------------------------------------
  localparam int unsigned T_0MS_NS = 0;
  localparam int unsigned T_0P0005MS_NS = 500;
  localparam int unsigned T_0P001MS_NS = 1000;
  localparam int unsigned T_0P002MS_NS = 2000;
  localparam int unsigned T_0P005MS_NS = 5000;
  localparam int unsigned T_0P01MS_NS = 10000;
  localparam int unsigned T_0P05MS_NS = 50000;
  localparam int unsigned T_0P1MS_NS = 100000;
  localparam int unsigned T_0P25MS_NS = 250000;
  localparam int unsigned T_0P5MS_NS = 500000;
  localparam int unsigned T_1MS_NS = 1000000;
  localparam int unsigned T_2MS_NS = 2000000;
  localparam int unsigned T_4MS_NS = 4000000;
  localparam int unsigned T_12MS_NS = 12000000;

  // least times: round up to whole cycles
  localparam int unsigned CYC_0P0005MS = (T_0P0005MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_0P001MS = (T_0P001MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_0P002MS = (T_0P002MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_0P005MS = (T_0P005MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_0P01MS = (T_0P01MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_0P05MS = (T_0P05MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_0P1MS = (T_0P1MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_0P25MS = (T_0P25MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_0P5MS = (T_0P5MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_1MS = (T_1MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_2MS = (T_2MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_4MS = (T_4MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_12MS = (T_12MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // counter must hold the longest count (240000)
  localparam int unsigned CNT_W = 18;

  // ----------------------------------------------------------------
  // filter time selection codes
  // ----------------------------------------------------------------
  localparam int unsigned FILT_W = 4;
  localparam logic [FILT_W-1:0] FILT_0MS = 4'h0;
  localparam logic [FILT_W-1:0] FILT_0P0005MS = 4'h1;
  localparam logic [FILT_W-1:0] FILT_0P001MS = 4'h2;
  localparam logic [FILT_W-1:0] FILT_0P002MS = 4'h3;
  localparam logic [FILT_W-1:0] FILT_0P005MS = 4'h4;
  localparam logic [FILT_W-1:0] FILT_0P01MS = 4'h5;
  localparam logic [FILT_W-1:0] FILT_0P05MS = 4'h6;
  localparam logic [FILT_W-1:0] FILT_0P1MS = 4'h7;
  localparam logic [FILT_W-1:0] FILT_0P25MS = 4'h8;
  localparam logic [FILT_W-1:0] FILT_0P5MS = 4'h9;
  localparam logic [FILT_W-1:0] FILT_1MS = 4'ha;
  localparam logic [FILT_W-1:0] FILT_2MS = 4'hb;
  localparam logic [FILT_W-1:0] FILT_4MS = 4'hc;
  localparam logic [FILT_W-1:0] FILT_12MS = 4'hd;
  localparam logic [FILT_W-1:0] FILT_RESET = FILT_4MS;

  // ----------------------------------------------------------------
  // latch mode codes
  // ----------------------------------------------------------------
  localparam int unsigned LATCH_W = 3;
  localparam logic [LATCH_W-1:0] LATCH_OFF = 3'h0;
  localparam logic [LATCH_W-1:0] LATCH_RISE_AUTO = 3'h1;
  localparam logic [LATCH_W-1:0] LATCH_FALL_AUTO = 3'h2;
  localparam logic [LATCH_W-1:0] LATCH_BOTH_AUTO = 3'h3;
  localparam logic [LATCH_W-1:0] LATCH_RISE_MAN = 3'h4;
  localparam logic [LATCH_W-1:0] LATCH_FALL_MAN = 3'h5;
  localparam logic [LATCH_W-1:0] LATCH_BOTH_MAN = 3'h6;
  localparam logic [LATCH_W-1:0] LATCH_RESET = LATCH_OFF;

endpackage
`default_nettype wire

/* File: design/input_debounce.sv */
// one channel of input debounce filtering
`default_nettype none
module input_debounce
  import input_latch_debounce_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic din_i,
  input wire logic [CNT_W-1:0] limit_i,
  output logic level_o
);

  typedef struct packed {
    logic level;
    logic [CNT_W-1:0] cnt;
  } deb_state_t;

  deb_state_t st_reg;
  deb_state_t st_next;

  // ----------------------------------------------------------------
  // filter
  // ----------------------------------------------------------------
  // the new level must differ for limit+1 cycles, i.e. longer than the filter time
  always_comb begin
    st_next = st_reg;
    if (din_i == st_reg.level) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt >= limit_i) begin // [R04]
      st_next.level = din_i;
      st_next.cnt = '0;
    end else begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_o = st_reg.level;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  property p_r04_hold;
    (din_i != st_reg.level && st_reg.cnt < limit_i) |=> $stable(st_reg.level);
  endproperty
  a_r04_hold: assert property (p_r04_hold) else $error("level changed before filter time"); // [R04]

  property p_r04_cause;
    ##1 $changed(st_reg.level) |-> $past(din_i) != $past(st_reg.level) && $past(st_reg.cnt) >= $past(limit_i);
  endproperty
  a_r04_cause: assert property (p_r04_cause) else $error("level change without persisted input"); // [R04]

endmodule // input_debounce
`default_nettype wire

/* File: design/input_latch_debounce.sv */
// debounced digital inputs with edge latch and host acknowledge
`default_nettype none

// Overview of operation
// R01: code 0 off; 1,4 rise; 2,5 fall; 3,6 both
// R02: qualifying pulse is held for later scan
// R03: codes 1-3 auto ack, 4-6 manual ack
// R04: level changes only after persisting beyond filter
// R05: fourteen filter times, default 4 ms
// R06: manual holds until ack; auto clears after report
module input_latch_debounce
  import input_latch_debounce_pkg::*;
#(
  parameter int NUM_CH = 2,
  parameter int unsigned FILT_CYC_0P25MS = CYC_0P25MS,
  parameter int unsigned FILT_CYC_0P5MS = CYC_0P5MS,
  parameter int unsigned FILT_CYC_1MS = CYC_1MS,
  parameter int unsigned FILT_CYC_2MS = CYC_2MS,
  parameter int unsigned FILT_CYC_4MS = CYC_4MS,
  parameter int unsigned FILT_CYC_12MS = CYC_12MS
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [NUM_CH-1:0] field_in_i,
  input wire logic cfg_load_i,
  input wire logic [NUM_CH*LATCH_W-1:0] latch_mode_i,
  input wire logic [NUM_CH*FILT_W-1:0] input_debounce_time_i,
  input wire logic scan_i,
  input wire logic [NUM_CH-1:0] ack_i,
  output logic [NUM_CH-1:0] filt_level_o,
  output logic [NUM_CH-1:0] latched_o,
  output logic [NUM_CH-1:0] scan_event_o
);

  typedef struct packed {
    logic [NUM_CH-1:0][LATCH_W-1:0] mode;
    logic [NUM_CH-1:0][FILT_W-1:0] filt;
    logic [NUM_CH-1:0] level;
    logic [NUM_CH-1:0] latch;
    logic [NUM_CH-1:0] event_seen;
  } top_state_t;

  top_state_t st_reg;
  top_state_t st_next;
  logic [NUM_CH-1:0] deb_level;
  logic [NUM_CH-1:0][CNT_W-1:0] limit;
  logic [NUM_CH-1:0] rise;
  logic [NUM_CH-1:0] fall;
  logic [NUM_CH-1:0] hit;
  logic [NUM_CH-1:0] manual;

  // ----------------------------------------------------------------
  // filter time lookup
  // ----------------------------------------------------------------
  // unknown codes fall back to no filtering rather than a surprise delay
  function automatic logic [CNT_W-1:0] filt_cycles(input logic [FILT_W-1:0] code);
    logic [CNT_W-1:0] r;
    case (code)
      FILT_0MS: r = CNT_W'(T_0MS_NS);
      FILT_0P0005MS: r = CNT_W'(CYC_0P0005MS);
      FILT_0P001MS: r = CNT_W'(CYC_0P001MS);
      FILT_0P002MS: r = CNT_W'(CYC_0P002MS);
      FILT_0P005MS: r = CNT_W'(CYC_0P005MS);
      FILT_0P01MS: r = CNT_W'(CYC_0P01MS);
      FILT_0P05MS: r = CNT_W'(CYC_0P05MS);
      FILT_0P1MS: r = CNT_W'(CYC_0P1MS);
      FILT_0P25MS: r = CNT_W'(FILT_CYC_0P25MS);
      FILT_0P5MS: r = CNT_W'(FILT_CYC_0P5MS);
      FILT_1MS: r = CNT_W'(FILT_CYC_1MS);
      FILT_2MS: r = CNT_W'(FILT_CYC_2MS);
      FILT_4MS: r = CNT_W'(FILT_CYC_4MS);
      FILT_12MS: r = CNT_W'(FILT_CYC_12MS);
      default: r = '0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // per-channel debounce filters
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign limit[c] = filt_cycles(st_reg.filt[c]); // [R05]

    input_debounce u_deb (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .din_i(field_in_i[c]),
      .limit_i(limit[c]),
      .level_o(deb_level[c])
    );

    assign rise[c] = deb_level[c] & ~st_reg.level[c];
    assign fall[c] = ~deb_level[c] & st_reg.level[c];
    assign manual[c] = (st_reg.mode[c] >= LATCH_RISE_MAN); // [R03]
    always_comb begin
      case (st_reg.mode[c]) // [R01]
        LATCH_RISE_AUTO, LATCH_RISE_MAN: hit[c] = rise[c];
        LATCH_FALL_AUTO, LATCH_FALL_MAN: hit[c] = fall[c];
        LATCH_BOTH_AUTO, LATCH_BOTH_MAN: hit[c] = rise[c] | fall[c];
        default: hit[c] = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // latch and report
  // ----------------------------------------------------------------
  // a new edge in the clearing cycle wins, so a pulse that meets a scan or ack is not dropped
  always_comb begin
    st_next = st_reg;
    for (int c = 0; c < NUM_CH; c++) begin
      if (cfg_load_i) begin
        // codes above the documented range are taken as latch off
        if (latch_mode_i[c*LATCH_W +: LATCH_W] > LATCH_BOTH_MAN) begin
          st_next.mode[c] = LATCH_OFF;
        end else begin
          st_next.mode[c] = latch_mode_i[c*LATCH_W +: LATCH_W];
        end
        st_next.filt[c] = input_debounce_time_i[c*FILT_W +: FILT_W]; // [R05]
      end
      st_next.level[c] = deb_level[c];
      if (scan_i) begin
        st_next.event_seen[c] = st_reg.latch[c]; // [R02]
      end
      if (st_reg.mode[c] == LATCH_OFF) begin
        st_next.latch[c] = 1'b0; // [R01]
      end else begin
        if (manual[c] && ack_i[c]) begin
          st_next.latch[c] = 1'b0; // [R06]
        end
        if (!manual[c] && scan_i) begin
          st_next.latch[c] = 1'b0; // [R06]
        end
        if (hit[c]) begin
          st_next.latch[c] = 1'b1; // [R02]
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st_reg.mode <= {NUM_CH{LATCH_RESET}};
      st_reg.filt <= {NUM_CH{FILT_RESET}}; // [R05]
      st_reg.level <= '0;
      st_reg.latch <= '0;
      st_reg.event_seen <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign filt_level_o = st_reg.level;
  assign latched_o = st_reg.latch;
  assign scan_event_o = st_reg.event_seen;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  property p_r05_default;
    disable iff (1'b0) srst_i |=> st_reg.filt[0] == FILT_RESET && st_reg.mode[0] == LATCH_OFF;
  endproperty
  a_r05_default: assert property (p_r05_default) else $error("filter default not 4 ms"); // [R05]

  property p_r05_map;
    st_reg.filt[0] == FILT_0P0005MS |-> limit[0] == CNT_W'(CYC_0P0005MS);
  endproperty
  a_r05_map: assert property (p_r05_map) else $error("filter code 1 maps to wrong count"); // [R05]

  for (genvar c = 0; c < NUM_CH; c++) begin : g_chk
    sequence s_edge_caught;
      hit[c] && st_reg.mode[c] != LATCH_OFF;
    endsequence

    sequence s_auto_report;
      scan_i && st_reg.latch[c] && !manual[c] && !hit[c];
    endsequence

    property p_r01_off;
      st_reg.mode[c] == LATCH_OFF |=> !st_reg.latch[c];
    endproperty
    a_r01_off: assert property (p_r01_off) else $error("latch set while latching disabled"); // [R01]

    property p_r01_rise;
      (st_reg.mode[c] == LATCH_RISE_AUTO || st_reg.mode[c] == LATCH_RISE_MAN) && fall[c] |-> !hit[c];
    endproperty
    a_r01_rise: assert property (p_r01_rise) else $error("rising mode reacted to falling edge"); // [R01]

    property p_r02_catch;
      s_edge_caught |=> st_reg.latch[c];
    endproperty
    a_r02_catch: assert property (p_r02_catch) else $error("edge not latched"); // [R02]

    property p_r02_report;
      st_reg.latch[c] && scan_i |=> st_reg.event_seen[c];
    endproperty
    a_r02_report: assert property (p_r02_report) else $error("latched event not reported on scan"); // [R02]

    property p_r03_manual_hold;
      st_reg.latch[c] && manual[c] && !ack_i[c] && !cfg_load_i |=> st_reg.latch[c];
    endproperty
    a_r03_manual_hold: assert property (p_r03_manual_hold) else $error("manual latch lost without ack"); // [R03]

    property p_r06_auto_clear;
      s_auto_report |=> !st_reg.latch[c] && st_reg.event_seen[c];
    endproperty
    a_r06_auto_clear: assert property (p_r06_auto_clear) else $error("auto latch not cleared after report"); // [R06]

    property p_r06_ack;
      st_reg.latch[c] && manual[c] && ack_i[c] && !hit[c] |=> !st_reg.latch[c] ##1 (!st_reg.latch[c] || $past(hit[c]));
    endproperty
    a_r06_ack: assert property (p_r06_ack) else $error("manual latch not cleared by ack"); // [R06]
  end

endmodule // input_latch_debounce
`default_nettype wire

/* File: bench/field_scan_model.sv */
// far-side model: field input levels and host scan and acknowledge strobes
`default_nettype none
module field_scan_model #(
  parameter int N = 2
) (
  input wire logic core_clk_i,
  output logic [N-1:0] field_o,
  output logic scan_o,
  output logic [N-1:0] ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // strobes
  // ----------------------------------------------------------------
  initial begin
    field_o = '0;
    scan_o = 1'b0;
    ack_o = '0;
  end
  task automatic level(input int ch, input logic v);
    @(negedge core_clk_i);
    field_o[ch] = v;
  endtask
  // single-cycle scan, far apart: the host is slower than the field pulses
  task automatic scan();
    @(negedge core_clk_i);
    scan_o = 1'b1;
    @(negedge core_clk_i);
    scan_o = 1'b0;
  endtask
  // acknowledge only after a scan has reported the event
  task automatic ack(input int ch);
    @(negedge core_clk_i);
    ack_o[ch] = 1'b1;
    @(negedge core_clk_i);
    ack_o[ch] = 1'b0;
  endtask
endmodule // field_scan_model
`default_nettype wire

/* File: bench/tb_input_latch_debounce.sv */
// self-checking bench for the debounced input latch block
`default_nettype none
module tb_input_latch_debounce
  import input_latch_debounce_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // set-up
  // ----------------------------------------------------------------
  // long filter counts shortened so the run stays brief; codes 14 and 15 mean no filter
  localparam int LIMS[16] = '{0, CYC_0P0005MS, CYC_0P001MS, CYC_0P002MS, CYC_0P005MS, CYC_0P01MS,
    CYC_0P05MS, CYC_0P1MS, 20, 30, 40, 50, 60, 70, 0, 0};
  logic core_clk_i;
  logic srst_i = 1'b1;
  logic cfg_load_i = 1'b0;
  logic [5:0] latch_mode_i = '0;
  logic [7:0] input_debounce_time_i = '0;
  wire logic [1:0] field_in_i;
  wire logic [1:0] ack_i;
  wire logic scan_i;
  logic [1:0] filt_level_o;
  logic [1:0] latched_o;
  logic [1:0] scan_event_o;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] rng = 32'h27;

  input_latch_debounce #(.NUM_CH(2), .FILT_CYC_0P25MS(LIMS[8]), .FILT_CYC_0P5MS(LIMS[9]),
    .FILT_CYC_1MS(LIMS[10]), .FILT_CYC_2MS(LIMS[11]), .FILT_CYC_4MS(LIMS[12]), .FILT_CYC_12MS(LIMS[13])
  ) u_dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .field_in_i(field_in_i), .cfg_load_i(cfg_load_i),
    .latch_mode_i(latch_mode_i), .input_debounce_time_i(input_debounce_time_i), .scan_i(scan_i),
    .ack_i(ack_i), .filt_level_o(filt_level_o), .latched_o(latched_o), .scan_event_o(scan_event_o));

  field_scan_model #(.N(2)) u_far (.core_clk_i(core_clk_i), .field_o(field_in_i), .scan_o(scan_i),
    .ack_o(ack_i));

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  function automatic int rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return int'(rng & 32'h7fffffff);
  endfunction

  task automatic complete_run();
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic cfg(input logic [2:0] m, input logic [3:0] f);
    @(negedge core_clk_i);
    cfg_load_i = 1'b1;
    latch_mode_i = {2{m}};
    input_debounce_time_i = {2{f}};
    @(negedge core_clk_i);
    cfg_load_i = 1'b0;
  endtask

  // count edges from a held change until the filtered level follows it
  task automatic settle(input int ch, input logic v, input int l);
    int n;
    n = 0;
    u_far.level(ch, v);
    while (filt_level_o[ch] !== v && n < 3000) begin
      @(negedge core_clk_i);
      n++;
    end
    check("settle edges", n, l + 2);
  endtask

  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc >= 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    step(8);
    srst_i = 1'b0;
    settle(0, 1'b1, LIMS[12]);
    check("latch off default", latched_o, 2'h0);
    settle(0, 1'b0, LIMS[12]);
    for (int c = 0; c < 16; c++) begin
      int ch;
      int w;
      ch = rnd() % 2;
      cfg(3'h0, c[3:0]);
      settle(ch, 1'b1, LIMS[c]);
      settle(ch, 1'b0, LIMS[c]);
      if (LIMS[c] > 0 && LIMS[c] <= 200) begin
        // odd codes sit exactly on the limit, even ones anywhere from 1 up to it
        w = (c % 2) ? LIMS[c] : 1 + rnd() % LIMS[c];
        u_far.level(ch, 1'b1);
        step(w - 1);
        u_far.level(ch, 1'b0);
        // look right after the pulse, while a level taken one edge early would still show
        step(2);
        check("short pulse end", filt_level_o[ch], 1'b0);
        step(LIMS[c] + 2);
        check("short pulse", filt_level_o[ch], 1'b0);
      end
    end
    for (int m = 0; m < 8; m++) begin
      logic r;
      logic f;
      logic man;
      int ch;
      r = m inside {1, 3, 4, 6};
      f = m inside {2, 3, 5, 6};
      man = m inside {4, 5, 6};
      ch = rnd() % 2;
      cfg(m[2:0], 4'h0);
      for (int e = 0; e < 2; e++) begin
        logic s;
        s = e ? f : r;
        settle(ch, e == 0, 0);
        check("latched", latched_o[ch], s);
        u_far.scan();
        step(1);
        check("scan event", scan_event_o[ch], s);
        check("after scan", latched_o[ch], s & man);
        u_far.ack(ch);
        step(1);
        check("after ack", latched_o[ch], 1'b0);
      end
    end
    cfg(LATCH_RISE_MAN, FILT_0MS);
    u_far.level(1, 1'b1);
    u_far.level(1, 1'b0);
    step(20);
    check("narrow pulse held", latched_o[1], 1'b1);
    u_far.scan();
    step(1);
    check("narrow pulse seen", scan_event_o[1], 1'b1);
    srst_i = 1'b1;
    step(2);
    srst_i = 1'b0;
    check("reset latch", latched_o, 2'h0);
    complete_run();
  end
endmodule // tb_input_latch_debounce
`default_nettype wire
